// ### rtl/eeprom_read_target.sv
`timescale 1ns/10ps
module eeprom_read_target #(
  parameter int ADDR_W = eeprom_link_pkg::ADDR_W_DEFAULT,
  parameter logic [3:0] TYPE_ID = eeprom_link_pkg::TYPE_ID_DEFAULT
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // link
  eeprom_link_if.target link,
  // straps and status
  input wire logic write_protect_input,
  input wire logic chip_select_bit0,
  input wire logic chip_select_bit1,
  input wire logic chip_select_bit2,
  input wire logic write_busy,
  output logic selected
);
  if (ADDR_W < 1 || ADDR_W > 8) begin : g_addr_chk
    $error("ADDR_W out of range");
  end
  localparam int DEPTH = 1 << ADDR_W;
  typedef enum logic [2:0] {IDLE, SEL, SEL_ACK, ADDR, ADDR_ACK, TX, TX_ACK} state_t;
  // ***************************************************
  // pin sampling and edge detection
  // ***************************************************
  // both pins share one synchroniser, so sda is seen in step with scl
  // a start or stop needs scl high on two samples running
  logic [1:0] pins;
  logic scl_prev_q, sda_prev_q;
  logic scl, sda, scl_rise, scl_fall, start_ev, stop_ev;
  pin_sync #(.WIDTH(2)) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin_in({link.scl, link.sda}),
    .pin_out(pins)
  );
  assign scl = pins[1];
  assign sda = pins[0];
  assign scl_rise = scl && !scl_prev_q;
  assign scl_fall = !scl && scl_prev_q;
  assign start_ev = scl && scl_prev_q && sda_prev_q && !sda;
  assign stop_ev = scl && scl_prev_q && !sda_prev_q && sda;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl;
      sda_prev_q <= sda;
    end
  end
  // ***************************************************
  // memory array
  // ***************************************************
  // read-only image; writes are outside this block
  // so the array only ever holds its erased content
  logic [7:0] mem_q [DEPTH];
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= eeprom_link_pkg::ERASED_BYTE;
      end
    end
  end
  // ***************************************************
  // protocol engine
  // ***************************************************
  state_t state_q, state_d;
  logic [7:0] shift_q, shift_d;
  logic [3:0] bit_q, bit_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic drive_low_q, drive_low_d;
  logic sel_q, sel_d;
  logic [2:0] chip_sel;
  // write_protect_input intentionally does not gate reads
  assign chip_sel = {chip_select_bit2, chip_select_bit1, chip_select_bit0};
  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    bit_d = bit_q;
    addr_d = addr_q;
    drive_low_d = drive_low_q;
    sel_d = sel_q;
    if (write_busy) begin
      state_d = IDLE;
      drive_low_d = 1'b0;
      sel_d = 1'b0;
    end else if (stop_ev) begin
      state_d = IDLE;
      drive_low_d = 1'b0;
      sel_d = 1'b0;
    end else if (start_ev) begin
      state_d = SEL;
      bit_d = '0;
      drive_low_d = 1'b0;
    end else begin
      unique case (state_q)
        IDLE: begin
          drive_low_d = 1'b0;
        end
        SEL, ADDR: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda};
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'(eeprom_link_pkg::BITS_PER_BYTE)) begin
            bit_d = '0;
            if (state_q == ADDR) begin
              addr_d = shift_q[ADDR_W-1:0];
              drive_low_d = 1'b1;
              state_d = ADDR_ACK;
            end else if (shift_q[eeprom_link_pkg::TYPE_MSB:eeprom_link_pkg::TYPE_LSB] == TYPE_ID
                && shift_q[eeprom_link_pkg::CHIP_MSB:eeprom_link_pkg::CHIP_LSB] == chip_sel) begin
              drive_low_d = 1'b1;
              sel_d = 1'b1;
              state_d = SEL_ACK;
            end else begin
              sel_d = 1'b0;
              state_d = IDLE;
            end
          end
        end
        SEL_ACK, ADDR_ACK: begin
          if (scl_fall) begin
            if (state_q == SEL_ACK && shift_q[eeprom_link_pkg::DIR_BIT] == eeprom_link_pkg::DIR_READ) begin
              shift_d = mem_q[addr_q];
              addr_d = addr_q + 1'b1;
              drive_low_d = !mem_q[addr_q][7];
              bit_d = 4'h1;
              state_d = TX;
            end else begin
              drive_low_d = 1'b0;
              state_d = (state_q == SEL_ACK) ? ADDR : IDLE;
            end
          end
        end
        TX: begin
          if (scl_fall) begin
            if (bit_q == 4'(eeprom_link_pkg::BITS_PER_BYTE)) begin
              drive_low_d = 1'b0;
              state_d = TX_ACK;
            end else begin
              shift_d = {shift_q[6:0], 1'b1};
              drive_low_d = !shift_q[6];
              bit_d = bit_q + 4'h1;
            end
          end
        end
        // ninth bit: a master ack keeps the stream going
        TX_ACK: begin
          if (scl_rise) begin
            if (sda) begin
              sel_d = 1'b0;
              state_d = IDLE;
            end else begin
              shift_d = mem_q[addr_q];
              addr_d = addr_q + 1'b1;
              bit_d = '0;
            end
          end else if (scl_fall && bit_q == '0) begin
            drive_low_d = !shift_q[7];
            bit_d = 4'h1;
            state_d = TX;
          end
        end
        default: state_d = IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= IDLE;
      shift_q <= '0;
      bit_q <= '0;
      addr_q <= '0;
      drive_low_q <= 1'b0;
      sel_q <= 1'b0;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      bit_q <= bit_d;
      addr_q <= addr_d;
      drive_low_q <= drive_low_d;
      sel_q <= sel_d;
    end
  end
  assign link.sda_s_out = 1'b0;
  assign link.sda_s_oe = drive_low_q;
  assign selected = sel_q;
endmodule

// ### rtl/eeprom_link_pkg.sv
package eeprom_link_pkg;
  // ***************************************************
  // select code layout
  // ***************************************************
  localparam int TYPE_MSB = 7;
  localparam int TYPE_LSB = 4;
  localparam int CHIP_MSB = 3;
  localparam int CHIP_LSB = 1;
  localparam int DIR_BIT = 0;
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;
  // arbitrary neutral type identifier
  localparam logic [3:0] TYPE_ID_DEFAULT = 4'h5;
  // ***************************************************
  // memory and timing
  // ***************************************************
  localparam int ADDR_W_DEFAULT = 8;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int BITS_PER_BYTE = 8;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCL_HALF_NS = 1250;
  localparam int SCL_HALF_CYC = SCL_HALF_NS / CLK_PERIOD_NS;
endpackage

// ### rtl/eeprom_link_if.sv
`timescale 1ns/10ps
interface eeprom_link_if;
  logic scl;
  logic sda_m_out;
  logic sda_m_oe;
  logic sda_s_out;
  logic sda_s_oe;
  logic sda;
  // open-drain wired level with pull-up
  assign sda = !((sda_m_oe && !sda_m_out) || (sda_s_oe && !sda_s_out));
  modport target (
    input scl,
    input sda,
    output sda_s_out,
    output sda_s_oe
  );
  modport master (
    output scl,
    input sda,
    output sda_m_out,
    output sda_m_oe
  );
endinterface

// ### rtl/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // pins
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;
  always_comb begin
    meta_d = pin_in;
    sync_d = meta_q;
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign pin_out = sync_q;
endmodule

// ### rtl/eeprom_read_master.sv
`timescale 1ns/10ps
module eeprom_read_master #(
  parameter int HALF_CYC = eeprom_link_pkg::SCL_HALF_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // link
  eeprom_link_if.master link,
  // command
  input wire logic cmd_valid,
  input wire logic cmd_random,
  input wire logic [6:0] cmd_select,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_count,
  output logic cmd_ready,
  // answer
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic nak_err
);
  if (HALF_CYC < 2) begin : g_half_chk
    $error("HALF_CYC too small");
  end
  typedef enum logic [2:0] {IDLE, START, BYTE, ACK, RSTART, STOP} state_t;
  logic [1:0] pins;
  pin_sync #(.WIDTH(2)) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin_in({link.scl, link.sda}),
    .pin_out(pins)
  );
  state_t st_q, st_d;
  logic [15:0] tick_q, tick_d;
  logic [1:0] ph_q, ph_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, cnt_q, cnt_d, sel_q, sel_d, ad_q, ad_d, dat_q, dat_d;
  logic [1:0] stage_q, stage_d;
  logic rnd_q, rnd_d, scl_q, scl_d, low_q, low_d, tx_q, tx_d;
  logic rdy_q, rdy_d, rv_q, rv_d, nak_q, nak_d;
  logic tick;
  assign tick = tick_q == 16'(HALF_CYC - 1);
  always_comb begin
    st_d = st_q; tick_d = tick ? '0 : tick_q + 16'h1; ph_d = ph_q; bit_d = bit_q;
    sh_d = sh_q; cnt_d = cnt_q; sel_d = sel_q; ad_d = ad_q; dat_d = dat_q; stage_d = stage_q;
    rnd_d = rnd_q; scl_d = scl_q; low_d = low_q; tx_d = tx_q;
    rdy_d = (st_q == IDLE) && !cmd_valid; rv_d = 1'b0; nak_d = 1'b0;
    unique case (st_q)
      IDLE: begin
        if (cmd_valid && rdy_q) begin
          sel_d = {cmd_select, !cmd_random};
          ad_d = cmd_addr; cnt_d = cmd_count; rnd_d = cmd_random; stage_d = '0;
          ph_d = '0; st_d = START; rdy_d = 1'b0;
        end
      end
      START, RSTART: if (tick) begin
        ph_d = ph_q + 2'h1;
        if (ph_q == 2'h0) begin scl_d = 1'b0; low_d = 1'b0; end
        if (ph_q == 2'h1) scl_d = 1'b1;
        if (ph_q == 2'h2) low_d = 1'b1;
        if (ph_q == 2'h3) begin
          scl_d = 1'b0; sh_d = (st_q == RSTART) ? {sel_q[7:1], 1'b1} : sel_q;
          tx_d = 1'b1; bit_d = '0; ph_d = '0; st_d = BYTE;
        end
      end
      BYTE: if (tick) begin
        if (!scl_q) begin
          low_d = tx_q ? !sh_q[7] : 1'b0;
          scl_d = 1'b1;
        end else begin
          scl_d = 1'b0; sh_d = {sh_q[6:0], pins[0]}; bit_d = bit_q + 4'h1;
          if (bit_q == 4'h7) begin
            st_d = ACK;
            if (!tx_q) begin dat_d = {sh_q[6:0], pins[0]}; rv_d = 1'b1; end
          end
        end
      end
      ACK: if (tick) begin
        if (!scl_q) begin
          low_d = !tx_q && cnt_q > 8'h1;
          scl_d = 1'b1;
        end else begin
          scl_d = 1'b0; bit_d = '0; st_d = BYTE;
          if (tx_q && pins[0]) begin nak_d = 1'b1; st_d = STOP; ph_d = '0; end
          else if (!tx_q) begin
            cnt_d = cnt_q - 8'h1; tx_d = 1'b0;
            if (cnt_q <= 8'h1) begin st_d = STOP; ph_d = '0; end
          end else if (rnd_q && stage_q == 2'h0) begin sh_d = ad_q; stage_d = 2'h1; end
          else if (rnd_q && stage_q == 2'h1) begin st_d = RSTART; ph_d = '0; stage_d = 2'h2; end
          else tx_d = 1'b0;
        end
      end
      STOP: if (tick) begin
        ph_d = ph_q + 2'h1;
        if (ph_q == 2'h0) low_d = 1'b1;
        if (ph_q == 2'h1) scl_d = 1'b1;
        if (ph_q == 2'h2) begin low_d = 1'b0; st_d = IDLE; end
      end
      default: st_d = IDLE;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_q <= IDLE; tick_q <= '0; ph_q <= '0; bit_q <= '0; sh_q <= '0; cnt_q <= '0;
      sel_q <= '0; ad_q <= '0; dat_q <= '0; stage_q <= '0; rnd_q <= 1'b0; scl_q <= 1'b1;
      low_q <= 1'b0; tx_q <= 1'b0; rdy_q <= 1'b0; rv_q <= 1'b0; nak_q <= 1'b0;
    end else begin
      st_q <= st_d; tick_q <= tick_d; ph_q <= ph_d; bit_q <= bit_d; sh_q <= sh_d; cnt_q <= cnt_d;
      sel_q <= sel_d; ad_q <= ad_d; dat_q <= dat_d; stage_q <= stage_d; rnd_q <= rnd_d; scl_q <= scl_d;
      low_q <= low_d; tx_q <= tx_d; rdy_q <= rdy_d; rv_q <= rv_d; nak_q <= nak_d;
    end
  end
  assign link.scl = scl_q;
  assign link.sda_m_out = 1'b0;
  assign link.sda_m_oe = low_q;
  assign cmd_ready = rdy_q;
  assign rd_data = dat_q;
  assign rd_valid = rv_q;
  assign nak_err = nak_q;
endmodule

// ### testbench/eeprom_link_assertions.sv
`timescale 1ns/10ps
module eeprom_link_assertions #(
  parameter int HALF_CYC = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // link
  input wire logic scl,
  input wire logic sda_m_out,
  input wire logic sda_m_oe,
  input wire logic sda_s_out,
  input wire logic sda_s_oe,
  input wire logic sda
);
  // ***************************************************
  // scl high run length
  // ***************************************************
  logic [7:0] hi_q;
  logic [7:0] hi_d;
  always_comb begin
    hi_d = scl ? hi_q + 8'h01 : 8'h00;
    if (hi_q == 8'hFF) hi_d = hi_q;
  end
  always_ff @(posedge clk_sys) begin
    hi_q <= sys_rst ? 8'h00 : hi_d;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // ***************************************************
  // link checks
  // ***************************************************
  a_reset_idle: assert property (disable iff (1'b0) sys_rst |=> scl && !sda_m_oe && !sda_s_oe)
    else $error("link not idle after reset");
  a_target_edge_low: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("target changed sda while scl high");
  a_target_pull_short: assert property ($rose(sda_s_oe) |-> ##[1:120] !sda_s_oe)
    else $error("target held sda too long");
  a_stop_target_quiet: assert property (scl && $past(scl) && $rose(sda) |-> (!sda_s_oe)[*8])
    else $error("target drives sda after stop");
  a_start_by_master: assert property (scl && $past(scl) && $fell(sda) |-> !sda_s_oe)
    else $error("target caused a start");
  a_scl_high_min: assert property ($fell(scl) |-> hi_q >= HALF_CYC)
    else $error("scl high phase too short");
  a_scl_low_bounded: assert property ($fell(scl) |-> ##[1:64] scl)
    else $error("scl stuck low");
  a_stop_scl_holds: assert property (scl && $past(scl) && $rose(sda) |-> scl[*4])
    else $error("scl dropped right after stop");
  c_stop: cover property (scl && $past(scl) && $rose(sda));
  c_start: cover property (scl && $past(scl) && $fell(sda));
  c_target_ack: cover property ($rose(sda_s_oe));
endmodule

// ### testbench/test_serial_eeprom_read_engine.sv
`timescale 1ns/10ps
module test_serial_eeprom_read_engine;
  // ***************************************************
  // bench signals
  // ***************************************************
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic wp = 1'b0;
  logic busy = 1'b0;
  logic cv = 1'b0;
  logic rnd = 1'b0;
  logic [6:0] sel = 7'h00;
  logic [7:0] adr = 8'h00;
  logic [7:0] cnt = 8'h01;
  logic [7:0] rd_data;
  logic cmd_ready, rd_valid, nak_err, selected;
  int n_errors = 0;
  int tests_run = 0;
  eeprom_link_if link ();
  eeprom_read_master #(.HALF_CYC(4)) i_eeprom_read_master (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .link(link.master), .cmd_valid(cv), .cmd_random(rnd), .cmd_select(sel), .cmd_addr(adr),
    .cmd_count(cnt), .cmd_ready(cmd_ready), .rd_data(rd_data), .rd_valid(rd_valid), .nak_err(nak_err));
  eeprom_read_target i_eeprom_read_target (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link.target),
    .write_protect_input(wp), .chip_select_bit0(1'b1), .chip_select_bit1(1'b0),
    .chip_select_bit2(1'b1), .write_busy(busy), .selected(selected));
  eeprom_link_assertions #(.HALF_CYC(4)) i_eeprom_link_assertions (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .scl(link.scl), .sda_m_out(link.sda_m_out), .sda_m_oe(link.sda_m_oe),
    .sda_s_out(link.sda_s_out), .sda_s_oe(link.sda_s_oe), .sda(link.sda));
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ***************************************************
  // tasks
  // ***************************************************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one read command; every byte must come back erased
  task automatic rd(input logic r, input logic [2:0] chip, input logic [7:0] a, input logic [7:0] n,
    input logic [7:0] nb, input logic nk);
    int k;
    int got;
    logic saw;
    k = 0;
    got = 0;
    saw = 1'b0;
    while (cmd_ready !== 1'b1 && k < 100) begin
      @(posedge clk_sys);
      #1 k++;
    end
    check("ready timeout", {7'h00, k >= 100}, 8'h00);
    cv = 1'b1;
    rnd = r;
    sel = {eeprom_link_pkg::TYPE_ID_DEFAULT, chip};
    adr = a;
    cnt = n;
    @(posedge clk_sys);
    #1 cv = 1'b0;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 4000) begin
      if (rd_valid === 1'b1) begin
        got++;
        check("rd_data", rd_data, eeprom_link_pkg::ERASED_BYTE);
      end
      if (nak_err === 1'b1) saw = 1'b1;
      @(posedge clk_sys);
      #1 k++;
    end
    check("done timeout", {7'h00, k >= 4000}, 8'h00);
    check("byte count", got[7:0], nb);
    check("nak_err", {7'h00, saw}, {7'h00, nk});
    check("selected", {7'h00, selected}, 8'h00);
    $display("read done chip %0d count %0d mismatches %0d", chip, n, n_errors);
  endtask
  // ***************************************************
  // tests
  // ***************************************************
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_errors++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    rd(1'b0, 3'h5, 8'h00, 8'h01, 8'h01, 1'b0);
    rd(1'b1, 3'h5, 8'hFE, 8'h01, 8'h01, 1'b0);
    rd(1'b1, 3'h5, 8'hFE, 8'h04, 8'h04, 1'b0);
    rd(1'b0, 3'h5, 8'h00, 8'h03, 8'h03, 1'b0);
    for (int c = 0; c < 8; c++) begin
      rd(1'b0, c[2:0], 8'h00, 8'h01, (c == 5) ? 8'h01 : 8'h00, c != 5);
    end
    busy = 1'b1;
    rd(1'b1, 3'h5, 8'h10, 8'h01, 8'h00, 1'b1);
    busy = 1'b0;
    wp = 1'b1;
    rd(1'b1, 3'h5, 8'h10, 8'h02, 8'h02, 1'b0);
    rd(1'b0, 3'h5, 8'h00, 8'h01, 8'h01, 1'b0);
    wp = 1'b0;
    close_out();
  end
endmodule
